// >>> core/scfg_pkg.sv
package scfg_pkg;
  localparam logic [7:0] ADDR_HS_MODE = 8'h00;
  localparam logic [7:0] ADDR_AUX_MODE = 8'h01;
  localparam logic [7:0] ADDR_RX_SET = 8'h10;
  localparam logic [7:0] ADDR_PULSE_LO = 8'h11;
  localparam logic [7:0] ADDR_PULSE_HI = 8'h12;
  localparam logic [7:0] ADDR_EQ_LO = 8'h13;
  localparam logic [7:0] ADDR_EQ_HI = 8'h14;
  localparam logic [7:0] ADDR_TX_SET = 8'h20;
  localparam logic [7:0] RST_HS_MODE = 8'h40;
  localparam logic [7:0] RST_AUX_MODE = 8'h40;
  localparam logic [7:0] RST_RX_SET = 8'h01;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [7:0] RST_TX_SET = 8'h03;
  localparam logic [7:0] MASK_MODE = 8'h43;
  localparam logic [7:0] MASK_RX = 8'h01;
  localparam logic [7:0] MASK_TX = 8'h0f;
  localparam int EN_BIT = 6;
  localparam logic [3:0] ADDR_UPPER = 4'h9;
  localparam int CLOCK_HZ = 10000000;
  localparam int PULSE_MS = 100;
  localparam int PULSE_CYCLES = (CLOCK_HZ / 1000) * PULSE_MS;
  localparam int PULSE_CW = 20;

  typedef struct packed {
    logic fastPathEnable;
    logic [1:0] fastSourceSelect;
    logic sidePathEnable;
    logic [1:0] sideSourceSelect;
    logic inputTerminationOn;
    logic [15:0] terminationPulseSelect;
    logic [15:0] equalizerLevelSelect;
    logic [1:0] outputEmphasisLevel;
    logic outputTerminationOn;
    logic outputCurrentLevel;
  } scfg_settings_t;

  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } scfg_bus_in_t;
endpackage : scfg_pkg

// >>> core/scfg_pulse_timer.sv
module scfg_pulse_timer
  import scfg_pkg::*;
#(
  parameter int CYCLES = PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic active
);
  logic [PULSE_CW-1:0] count;

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else if (start) begin
      count <= PULSE_CW'(CYCLES);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign active = (count != '0);
endmodule : scfg_pulse_timer

// >>> core/scfg_reg8.sv
module scfg_reg8
  import scfg_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic writeEn,
  input wire logic [7:0] writeData,
  output logic [7:0] value
);
  always_ff @(posedge clock) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else if (writeEn) begin
      value <= writeData & MASK;
    end
  end
endmodule : scfg_reg8

// >>> core/scfg_register_bank.sv
// Summary of operation
// RULE1: Registers reached only over two-wire serial bus.
// RULE2: Address low three bits come from straps.
// RULE3: Serial access locks out straps until reset.
// RULE4: Enable zero turns fast channels off, standby.
// RULE5: Fast select 00..11 picks sources A..D.
// RULE6: Side enable zero disconnects all side inputs.
// RULE7: Sixteen pulse bits split over two registers.
// RULE8: Side select 00..11 picks groups A..D.
// RULE9: Pulse bit drops termination 100 ms.
// RULE10: Termination bit gates all input terminations.
// RULE11: Equalizer bit picks low or high level.
// RULE12: Unused bits read zero, stray writes ignored.
module scfg_register_bank
  import scfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrStrap,
  input wire logic strapEnable,
  input wire logic [1:0] strapSource,
  input wire logic strapEqualizer,
  input wire logic [1:0] strapEmphasis,
  input wire logic strapOutTermination,
  input wire logic strapOutCurrent,
  output scfg_pkg::scfg_settings_t settings,
  output logic fastStandby,
  output logic [3:0] fastRouteOneHot,
  output logic [3:0] sideRouteOneHot,
  output logic [15:0] inputTermConnect,
  output logic serialLocked
);
  import scfg_pkg::*;

  typedef enum {S_IDLE, S_DEVADDR, S_ACKADDR, S_REGADDR, S_ACKREG,
    S_WDATA, S_ACKW, S_RDATA, S_ACKR, S_SKIP} scfg_state_t;

  scfg_state_t state;
  logic sclPrev;
  logic sdaPrev;
  logic [7:0] shiftReg;
  logic [3:0] bitCount;
  logic [7:0] regPtr;
  logic readMode;
  logic [7:0] readByte;
  logic [7:0] hsMode, auxMode, rxSet, pulseLo, pulseHi, eqLo, eqHi, txSet;
  logic [7:0] wrEn;
  logic writeStrobe;
  logic [7:0] next_readByte;
  logic [1:0] prevSource;
  logic sourceChange;
  logic [15:0] pulseActive;

  wire sclRise = sclIn && !sclPrev;
  wire sclFall = !sclIn && sclPrev;
  wire startCond = sclIn && sclPrev && sdaPrev && !sdaIn;
  wire stopCond = sclIn && sclPrev && !sdaPrev && sdaIn;
  wire [6:0] ownAddr = {ADDR_UPPER, addrStrap}; // RULE2

  always_ff @(posedge clock) begin
    if (rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
    end
  end

  // The slave follows the bus on the system clock, so SCL must stay well below its rate.
  always_ff @(posedge clock) begin // RULE1
    if (rst) begin
      state <= S_IDLE;
      bitCount <= 4'h0;
      shiftReg <= 8'h00;
      regPtr <= 8'h00;
      readMode <= 1'b0;
    end else if (startCond) begin
      state <= S_DEVADDR;
      bitCount <= 4'h0;
    end else if (stopCond) begin
      state <= S_IDLE;
    end else if (sclRise) begin
      unique case (state)
        S_DEVADDR, S_REGADDR, S_WDATA: begin
          shiftReg <= {shiftReg[6:0], sdaIn};
          bitCount <= bitCount + 4'h1;
        end
        S_RDATA: begin
          bitCount <= bitCount + 4'h1;
        end
        S_ACKR: begin
          if (sdaIn) begin
            state <= S_SKIP;
          end
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      unique case (state)
        S_DEVADDR: begin
          if (bitCount == 4'h8) begin
            if (shiftReg[7:1] == ownAddr) begin
              state <= S_ACKADDR;
              readMode <= shiftReg[0];
            end else begin
              state <= S_SKIP;
            end
          end
        end
        S_ACKADDR: begin
          bitCount <= 4'h0;
          state <= readMode ? S_RDATA : S_REGADDR;
        end
        S_REGADDR: begin
          if (bitCount == 4'h8) begin
            regPtr <= shiftReg;
            state <= S_ACKREG;
          end
        end
        S_ACKREG: begin
          bitCount <= 4'h0;
          state <= S_WDATA;
        end
        S_WDATA: begin
          if (bitCount == 4'h8) begin
            state <= S_ACKW;
          end
        end
        S_ACKW: begin
          bitCount <= 4'h0;
          regPtr <= regPtr + 8'h01;
          state <= S_WDATA;
        end
        S_RDATA: begin
          if (bitCount == 4'h8) begin
            state <= S_ACKR;
          end
        end
        S_ACKR: begin
          bitCount <= 4'h0;
          regPtr <= regPtr + 8'h01;
          state <= S_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  assign writeStrobe = sclFall && (state == S_WDATA) && (bitCount == 4'h8);

  // Writes to unmapped addresses are still acknowledged but land in no register.
  always_comb begin
    wrEn = 8'h00;
    if (writeStrobe) begin // RULE12
      unique case (regPtr)
        ADDR_HS_MODE: wrEn[0] = 1'b1;
        ADDR_AUX_MODE: wrEn[1] = 1'b1;
        ADDR_RX_SET: wrEn[2] = 1'b1;
        ADDR_PULSE_LO: wrEn[3] = 1'b1;
        ADDR_PULSE_HI: wrEn[4] = 1'b1;
        ADDR_EQ_LO: wrEn[5] = 1'b1;
        ADDR_EQ_HI: wrEn[6] = 1'b1;
        ADDR_TX_SET: wrEn[7] = 1'b1;
        default: wrEn = 8'h00;
      endcase
    end
  end

  scfg_reg8 #(.RESET_VALUE(RST_HS_MODE), .MASK(MASK_MODE)) uHs (.clock(clock), .rst(rst),
    .writeEn(wrEn[0]), .writeData(shiftReg), .value(hsMode));
  scfg_reg8 #(.RESET_VALUE(RST_AUX_MODE), .MASK(MASK_MODE)) uAux (.clock(clock), .rst(rst),
    .writeEn(wrEn[1]), .writeData(shiftReg), .value(auxMode));
  scfg_reg8 #(.RESET_VALUE(RST_RX_SET), .MASK(MASK_RX)) uRx (.clock(clock), .rst(rst),
    .writeEn(wrEn[2]), .writeData(shiftReg), .value(rxSet));
  scfg_reg8 #(.RESET_VALUE(RST_PULSE)) uPtLo (.clock(clock), .rst(rst), // RULE7
    .writeEn(wrEn[3]), .writeData(shiftReg), .value(pulseLo));
  scfg_reg8 #(.RESET_VALUE(RST_PULSE)) uPtHi (.clock(clock), .rst(rst), // RULE7
    .writeEn(wrEn[4]), .writeData(shiftReg), .value(pulseHi));
  scfg_reg8 #(.RESET_VALUE(RST_EQ)) uEqLo (.clock(clock), .rst(rst),
    .writeEn(wrEn[5]), .writeData(shiftReg), .value(eqLo));
  scfg_reg8 #(.RESET_VALUE(RST_EQ)) uEqHi (.clock(clock), .rst(rst),
    .writeEn(wrEn[6]), .writeData(shiftReg), .value(eqHi));
  scfg_reg8 #(.RESET_VALUE(RST_TX_SET), .MASK(MASK_TX)) uTx (.clock(clock), .rst(rst),
    .writeEn(wrEn[7]), .writeData(shiftReg), .value(txSet));

  always_comb begin
    unique case (regPtr)
      ADDR_HS_MODE: next_readByte = hsMode;
      ADDR_AUX_MODE: next_readByte = auxMode;
      ADDR_RX_SET: next_readByte = rxSet;
      ADDR_PULSE_LO: next_readByte = pulseLo;
      ADDR_PULSE_HI: next_readByte = pulseHi;
      ADDR_EQ_LO: next_readByte = eqLo;
      ADDR_EQ_HI: next_readByte = eqHi;
      ADDR_TX_SET: next_readByte = txSet;
      default: next_readByte = 8'h00; // RULE12
    endcase
  end

  // The read byte is captured as the data phase opens so it cannot shift mid-byte.
  always_ff @(posedge clock) begin
    if (rst) begin
      readByte <= 8'h00;
    end else if (sclFall && (state == S_ACKADDR || state == S_ACKR)) begin
      readByte <= next_readByte;
    end else if (sclFall && state == S_RDATA && bitCount != 4'h0) begin
      readByte <= {readByte[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
    end else if (startCond || stopCond) begin
      sdaOe <= 1'b0;
    end else if (sclFall) begin
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      if ((state == S_DEVADDR && bitCount == 4'h8 && shiftReg[7:1] == ownAddr) ||
          (state == S_REGADDR && bitCount == 4'h8) ||
          (state == S_WDATA && bitCount == 4'h8)) begin
        sdaOe <= 1'b1;
      end else if (state == S_ACKADDR && readMode || state == S_ACKR) begin
        sdaOe <= !next_readByte[7];
      end else if (state == S_RDATA && bitCount != 4'h8) begin
        sdaOe <= !readByte[6];
      end
    end
  end

  // Any addressed transfer counts as a serial access, a read included.
  always_ff @(posedge clock) begin
    if (rst) begin
      serialLocked <= 1'b0;
    end else if (state == S_ACKADDR) begin // RULE3
      serialLocked <= 1'b1;
    end
  end

  always_comb begin
    if (serialLocked) begin
      settings.fastPathEnable = hsMode[EN_BIT];
      settings.fastSourceSelect = hsMode[1:0];
      settings.sidePathEnable = auxMode[EN_BIT];
      settings.sideSourceSelect = auxMode[1:0];
      settings.inputTerminationOn = rxSet[0];
      settings.terminationPulseSelect = {pulseHi, pulseLo};
      settings.equalizerLevelSelect = {eqHi, eqLo}; // RULE11
      settings.outputEmphasisLevel = txSet[3:2];
      settings.outputTerminationOn = txSet[1];
      settings.outputCurrentLevel = txSet[0];
    end else begin // RULE3
      settings.fastPathEnable = strapEnable;
      settings.fastSourceSelect = strapSource;
      settings.sidePathEnable = RST_AUX_MODE[EN_BIT];
      settings.sideSourceSelect = strapSource;
      settings.inputTerminationOn = RST_RX_SET[0];
      settings.terminationPulseSelect = {RST_PULSE, RST_PULSE};
      settings.equalizerLevelSelect = {16{strapEqualizer}}; // RULE11
      settings.outputEmphasisLevel = strapEmphasis;
      settings.outputTerminationOn = strapOutTermination;
      settings.outputCurrentLevel = strapOutCurrent;
    end
  end

  assign fastStandby = !settings.fastPathEnable; // RULE4
  assign fastRouteOneHot = settings.fastPathEnable ?
    4'h1 << settings.fastSourceSelect : 4'h0; // RULE5
  assign sideRouteOneHot = settings.sidePathEnable ?
    4'h1 << settings.sideSourceSelect : 4'h0; // RULE6 RULE8

  always_ff @(posedge clock) begin
    if (rst) begin
      prevSource <= 2'h0;
    end else begin
      prevSource <= settings.fastSourceSelect;
    end
  end

  assign sourceChange = prevSource != settings.fastSourceSelect;

  // A new source restarts every selected timer, even one that is still running.
  for (genvar i = 0; i < 16; i++) begin : gPulse
    scfg_pulse_timer uTimer (
      .clock(clock),
      .rst(rst),
      .start(sourceChange && settings.terminationPulseSelect[i]), // RULE9
      .active(pulseActive[i])
    );
  end

  assign inputTermConnect = {16{settings.inputTerminationOn}} & ~pulseActive; // RULE10
endmodule : scfg_register_bank

// >>> tb/scfg_register_bank_chk.sv
module scfg_register_bank_chk
  import scfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOe,
  input wire logic sdaOut,
  input wire logic strapEnable,
  input wire logic [1:0] strapSource,
  input wire scfg_pkg::scfg_settings_t settings,
  input wire logic fastStandby,
  input wire logic [3:0] fastRouteOneHot,
  input wire logic [3:0] sideRouteOneHot,
  input wire logic [15:0] inputTermConnect,
  input wire logic serialLocked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_standby_enable: assert property (fastStandby == !settings.fastPathEnable)
    else $error("standby differs from enable");
  a_fast_off: assert property (fastStandby |-> fastRouteOneHot == 4'h0)
    else $error("fast route active in standby");
  a_fast_select: assert property (!fastStandby |->
    fastRouteOneHot == (4'h1 << settings.fastSourceSelect))
    else $error("fast route wrong");
  a_side_off: assert property (!settings.sidePathEnable |-> sideRouteOneHot == 4'h0)
    else $error("side route active while off");
  a_side_select: assert property (settings.sidePathEnable |->
    sideRouteOneHot == (4'h1 << settings.sideSourceSelect))
    else $error("side route wrong");
  a_term_gate: assert property (!settings.inputTerminationOn |-> inputTermConnect == 16'h0)
    else $error("termination on while off");
  a_term_steady: assert property (settings.inputTerminationOn |->
    (inputTermConnect | settings.terminationPulseSelect) == 16'hffff)
    else $error("unpulsed channel disconnected");
  a_lock_sticky: assert property (serialLocked |=> serialLocked)
    else $error("lock dropped without reset");
  a_strap_follow: assert property (!serialLocked |-> settings.fastPathEnable == strapEnable
    && settings.fastSourceSelect == strapSource)
    else $error("straps not applied before lock");
  a_answer_timing: assert property ($changed(sdaOe) |-> $past(sclIn, 2) && !$past(sclIn))
    else $error("data line changed off clock fall");
  a_drive_low: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
  c_locked: cover property ($rose(serialLocked));
  c_answer: cover property ($rose(sdaOe));
  c_standby: cover property (serialLocked && fastStandby);
endmodule : scfg_register_bank_chk

bind scfg_register_bank scfg_register_bank_chk scfg_register_bank_chk_i (.clock, .rst,
  .sclIn, .sdaOe, .strapEnable, .strapSource, .settings, .fastStandby, .fastRouteOneHot,
  .sideRouteOneHot, .inputTermConnect, .serialLocked, .sdaOut);

// >>> tb/scfg_i2c_master.sv
module scfg_i2c_master (
  input wire logic clock,
  input wire logic sdaOe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge clock);
  endtask : half
  // The line is sampled late in the high phase so the slave answer has settled.
  task automatic bitIo(input logic b, output logic seen);
    sda = b;
    half();
    scl = 1'b1;
    half();
    seen = sda & ~sdaOe;
    scl = 1'b0;
  endtask : bitIo
  task automatic start();
    sda = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda = 1'b1;
    half();
  endtask : stop
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bitIo(tx[i], rx[i]);
    end
  endtask : xfer
  task automatic writeReg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
    output logic ok);
    logic [8:0] x, y, z;
    start();
    xfer({a, 2'b01}, x);
    xfer({r, 1'b1}, y);
    xfer({d, 1'b1}, z);
    stop();
    ok = !(x[0] | y[0] | z[0]);
  endtask : writeReg
  task automatic readReg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
    output logic ok);
    logic [8:0] x, y, z, q;
    start();
    xfer({a, 2'b01}, x);
    xfer({r, 1'b1}, y);
    start();
    xfer({a, 2'b11}, z);
    xfer(9'h1ff, q);
    stop();
    d = q[8:1];
    ok = !(x[0] | y[0] | z[0]);
  endtask : readReg
endmodule : scfg_i2c_master

// >>> tb/tb_switch_config_register_bank.sv
module tb_switch_config_register_bank;
  import scfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, sdaOe, serialLocked, fastStandby, ok;
  logic [2:0] addrStrap = 3'h5;
  logic strapEnable = 1'b1;
  logic [1:0] strapSource = 2'h2;
  logic [1:0] strapEmphasis = 2'h1;
  logic strapCurrent = 1'b0;
  logic strapEqualizer = 1'b1;
  logic strapTermination = 1'b0;
  scfg_settings_t settings;
  logic [3:0] fastRouteOneHot, sideRouteOneHot;
  logic [15:0] inputTermConnect;
  int errors = 0;
  int comparisons = 0;
  always #50 clock = ~clock;
  scfg_i2c_master scfg_i2c_master_i (.clock, .sdaOe, .scl, .sda);
  scfg_register_bank scfg_register_bank_i (.clock, .rst, .sclIn(scl), .sdaIn(sda & ~sdaOe),
    .sdaOut(), .sdaOe, .addrStrap, .strapEnable, .strapSource, .strapEqualizer,
    .strapEmphasis, .strapOutTermination(strapTermination), .strapOutCurrent(strapCurrent),
    .settings,
    .fastStandby, .fastRouteOneHot, .sideRouteOneHot, .inputTermConnect, .serialLocked);
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    scfg_i2c_master_i.writeReg({4'h9, addrStrap}, r, d, ok);
    check("write ack", ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    scfg_i2c_master_i.readReg({4'h9, addrStrap}, r, d, ok);
    check("read ack", ok, 1'b1);
    check("read data", d, exp);
  endtask : rd
  task automatic test_straps();
    check("locked", serialLocked, 1'b0);
    check("source", fastRouteOneHot, 4'h4);
    check("emphasis", settings.outputEmphasisLevel, strapEmphasis);
    check("strap term", settings.outputTerminationOn, strapTermination);
    check("strap current", settings.outputCurrentLevel, strapCurrent);
    check("strap equalizer", settings.equalizerLevelSelect, 16'hffff);
    check("side default", sideRouteOneHot, 4'h4);
    check("term default", inputTermConnect, 16'hffff);
    scfg_i2c_master_i.writeReg({4'h9, addrStrap ^ 3'h1}, 8'h00, 8'h00, ok);
    check("foreign ack", ok, 1'b0);
    check("still open", serialLocked, 1'b0);
    $display("test_straps done");
  endtask : test_straps
  task automatic test_defaults();
    logic [7:0] adr [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h05};
    logic [7:0] val [9] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rd(adr[i], val[i]);
    end
    strapEnable = 1'b0;
    repeat (3) @(negedge clock);
    check("strap ignored", fastStandby, 1'b0);
    $display("test_defaults done");
  endtask : test_defaults
  task automatic test_routes();
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 8'h7c | 8'(s));
      rd(8'h00, 8'h40 | 8'(s));
      check("fast route", fastRouteOneHot, 4'h1 << s);
      wr(8'h01, 8'hfc | 8'(s));
      check("side route", sideRouteOneHot, 4'h1 << s);
    end
    wr(8'h01, 8'h03);
    check("side off", sideRouteOneHot, 4'h0);
    wr(8'h00, 8'h01);
    check("standby", fastStandby, 1'b1);
    check("fast off", fastRouteOneHot, 4'h0);
    $display("test_routes done");
  endtask : test_routes
  // The pulse lasts far longer than the run, so only its start is observed.
  task automatic test_pulse();
    wr(8'h11, 8'ha5);
    wr(8'h12, 8'h3c);
    check("pulse bits", settings.terminationPulseSelect, 16'h3ca5);
    wr(8'h00, 8'h42);
    check("pulsed", inputTermConnect, ~16'h3ca5);
    wr(8'h10, 8'hfe);
    rd(8'h10, 8'h00);
    check("term off", inputTermConnect, 16'h0);
    $display("test_pulse done");
  endtask : test_pulse
  task automatic test_misc();
    wr(8'h13, 8'h96);
    wr(8'h14, 8'h69);
    check("equalizer", settings.equalizerLevelSelect, 16'h6996);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h0f);
    check("tx emphasis", settings.outputEmphasisLevel, 2'h3);
    check("tx term", settings.outputTerminationOn, 1'b1);
    check("tx current", settings.outputCurrentLevel, 1'b1);
    wr(8'h30, 8'h55);
    rd(8'h13, 8'h96);
    rd(8'h30, 8'h00);
    $display("test_misc done");
  endtask : test_misc
  // A reset in mid-run must hand control back to the straps and restore defaults.
  task automatic test_reset();
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check("lock cleared", serialLocked, 1'b0);
    check("strap back", fastStandby, !strapEnable);
    check("route off", fastRouteOneHot, 4'h0);
    rd(8'h13, 8'h00);
    check("relocked", serialLocked, 1'b1);
    $display("test_reset done");
  endtask : test_reset
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    test_straps();
    test_defaults();
    test_routes();
    test_pulse();
    test_misc();
    test_reset();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule : tb_switch_config_register_bank
